// [pkg/pcfp_pkg.sv]
// What this block does
// - top two parcel bits give interface type; type sets meaning of rest.
// - function is ours only if bits 07, 08, 14, 15 match own values.
// - ignore bits 02 to 06; bits 00 to 01 are the subfunction.
// - on match, all four parcels are captured before the function runs.
// - call reply value loaded from parcel two on functions 10, 12, 17 only.
// - while interrupt pending, a passing call gets the call reply value.
// - memory priority: operand, then instruction, then channel transfers.
// - two 32-bit reference registers, upper and lower word halves.
// - 64-entry, 64-bit staging buffer carries all channel memory data.
// - address loaded from parcels three and four on 10,11,17,20,21,26,30,31,36.
// - functions 20 and 30 load length from low 10 bits of parcel two.
// - functions 26 and 36 load length from low seven bits of parcel two.
// - length forced to 1 for 21 and 31, 2 for 11, 4 for 10.
// - length register reopens for entry only after its function completes.
// - selected status bits raise error interrupt and send a stop pulse.
// - after error stop, wait for idle, then answer calls until bit clears.
// - decode functions 10-17, 20-23, 26, 27, 30-33, 36, 37.
// - function 10 loads four registers from low halves and starts processor in the same clock.
// - function 10: reply, address, read four words, start, blank response.
// - function 10 clears every instruction stack valid bit.
// - function 11 stores program address and status, zero upper, blank reply.
// - function pulse is one clock, four parcels in the next four clocks.
// - response is one-clock pulse then upper parcel, then lower parcel.
// - pending node overwrites the two blank parcels after a call pulse.
// - subfunction 0 status, 1 memory address, 2 error data register.
package pcfp_pkg;
  // ***********************************************************************
  // identity, fields
  // ***********************************************************************
  localparam logic [1:0] OWN_TYPE  = 2'h1; // arbitrary value
  localparam logic [1:0] OWN_ID    = 2'h0; // arbitrary value
  localparam int         TYPE_HI   = 15;
  localparam int         TYPE_LO   = 14;
  localparam int         ID_HI     = 8;
  localparam int         ID_LO     = 7;
  localparam int         FN_HI     = 13;
  localparam int         FN_LO     = 9;
  localparam int         SUB_HI    = 1;
  localparam int         SUB_LO    = 0;
  // ***********************************************************************
  // function codes
  // ***********************************************************************
  localparam logic [4:0] F_LOAD  = 5'h08;
  localparam logic [4:0] F_STORE = 5'h09;
  localparam logic [4:0] F_RUN   = 5'h0a;
  localparam logic [4:0] F_HALT  = 5'h0b;
  localparam logic [4:0] F_RDPC  = 5'h0c;
  localparam logic [4:0] F_WRPC  = 5'h0d;
  localparam logic [4:0] F_RDIF  = 5'h0e;
  localparam logic [4:0] F_WRIF  = 5'h0f;
  localparam logic [4:0] F_BLKCH = 5'h10;
  localparam logic [4:0] F_RDREF = 5'h11;
  localparam logic [4:0] F_RDUP  = 5'h12;
  localparam logic [4:0] F_RDLO  = 5'h13;
  localparam logic [4:0] F_BLKBF = 5'h16;
  localparam logic [4:0] F_BFREF = 5'h17;
  localparam logic [4:0] F_CHBLK = 5'h18;
  localparam logic [4:0] F_WRREF = 5'h19;
  localparam logic [4:0] F_ENUP  = 5'h1a;
  localparam logic [4:0] F_ENLO  = 5'h1b;
  localparam logic [4:0] F_BFMEM = 5'h1e;
  localparam logic [4:0] F_REFBF = 5'h1f;
  localparam logic [1:0] SUB_STAT = 2'h0;
  localparam logic [1:0] SUB_ADDR = 2'h1;
  localparam logic [1:0] SUB_ERR  = 2'h2;
  // ***********************************************************************
  // status bits, sizes, reset values
  // ***********************************************************************
  localparam int          IDLE_BIT  = 0;
  localparam logic [31:0] ERR_MASK  = 32'h0000ff00;
  localparam logic [6:0]  BUF_WORDS = 7'h40;
  localparam logic [31:0] RST_WORD  = 32'h00000000;
  localparam logic [15:0] RST_HALF  = 16'h0000;
  localparam logic [9:0]  RST_LEN   = 10'h000;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_CAPT = 6'h02,
    S_EXEC = 6'h04,
    S_MRD  = 6'h08,
    S_MWR  = 6'h10,
    S_DONE = 6'h20
  } pcfp_fsm_t;
endpackage

// [src/pcfp_top.sv]
`timescale 1ns/100ps
module pcfp_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] ch_data_in,
  input  wire logic        ch_func_in,
  input  wire logic        ch_resp_in,
  input  wire logic        ch_call_in,
  input  wire logic        ch_dpls_in,
  output logic      [15:0] ch_data_out,
  output logic             ch_func_out,
  output logic             ch_resp_out,
  output logic             ch_call_out,
  output logic             ch_dpls_out,
  input  wire logic        cm_opnd_req,
  input  wire logic        cm_inst_req,
  output logic             cm_gnt_opnd,
  output logic             cm_gnt_inst,
  output logic             cm_gnt_chan,
  output logic             cm_en,
  output logic             cm_we,
  output logic      [31:0] cm_addr,
  output logic      [63:0] cm_wdata,
  input  wire logic [63:0] cm_rdata,
  input  wire logic        cm_rvalid,
  input  wire logic [31:0] bp_pc_in,
  input  wire logic        bp_idle,
  input  wire logic [31:0] bp_err_set,
  output logic             bp_stop,
  output logic             bp_start,
  output logic             bp_istk_clr,
  output logic             bp_load,
  output logic             bp_pc_load,
  output logic      [31:0] bp_pc_val,
  output logic      [31:0] bp_stat_val,
  output logic      [31:0] bp_base_val,
  output logic      [31:0] limit_bound_register
);
  // ***********************************************************************
  // state
  // ***********************************************************************
  typedef struct packed {
    pcfp_pkg::pcfp_fsm_t st;
    logic [2:0]          pcnt;
    logic [3:0][15:0]    parc;
    logic                mine;
    logic [1:0]          call_cnt;
    logic [1:0]          resp_cnt;
    logic [31:0]         resp_data;
    logic [15:0]         interrupt_call_reply_value;
    logic [31:0]         upper_word_half_holder;
    logic [31:0]         lower_word_half_holder;
    logic [31:0]         memory_reference_pointer;
    logic [9:0]          block_transfer_word_count;
    logic                len_lock;
    logic [63:0][63:0]   buff;
    logic [31:0]         status;
    logic [31:0]         errdata;
    logic                stopped;
    logic                irq;
    logic [6:0]          widx;
    logic [6:0]          ridx;
    logic                cm_en;
    logic                cm_we;
    logic [31:0]         cm_addr;
    logic [63:0]         cm_wdata;
    logic                gnt_o;
    logic                gnt_i;
    logic                gnt_c;
    logic [15:0]         dout;
    logic                fout;
    logic                rout;
    logic                cout;
    logic                dpout;
    logic                stop_p;
    logic                start_p;
    logic                istk_clr;
    logic                load_p;
    logic                pc_load_p;
    logic [31:0]         pc_val;
    logic [31:0]         stat_val;
    logic [31:0]         base_val;
    logic [31:0]         lim_val;
  } pcfp_st_t;

  pcfp_st_t   q;
  pcfp_st_t   n;
  logic [4:0] fn;
  logic [1:0] sub;
  logic [31:0] adr;
  logic [6:0] nw;
  logic       err_hit;

  // words moved per pass, capped at the buffer size
  function automatic logic [6:0] mlen(input logic [9:0] len);
    if (len > {3'h0, pcfp_pkg::BUF_WORDS}) begin
      mlen = pcfp_pkg::BUF_WORDS;
    end else begin
      mlen = len[6:0];
    end
  endfunction

  // length entry, only while not held by an unfinished function
  function automatic logic [9:0] lenld(input logic lock,
                                       input logic [9:0] cur,
                                       input logic [9:0] val);
    lenld = lock ? cur : val;
  endfunction

  // ***********************************************************************
  // next state
  // ***********************************************************************
  always_comb begin
    n   = q;
    fn  = q.parc[0][pcfp_pkg::FN_HI:pcfp_pkg::FN_LO];
    sub = q.parc[0][pcfp_pkg::SUB_HI:pcfp_pkg::SUB_LO];
    adr = {q.parc[2], q.parc[3]};
    nw  = mlen(q.block_transfer_word_count);
    n.stop_p    = 1'b0;
    n.start_p   = 1'b0;
    n.istk_clr  = 1'b0;
    n.load_p    = 1'b0;
    n.pc_load_p = 1'b0;
    n.cm_en     = 1'b0;
    // relay stage
    n.dout  = ch_data_in;
    n.fout  = ch_func_in;
    n.rout  = ch_resp_in;
    n.cout  = ch_call_in;
    n.dpout = ch_dpls_in;
    // fixed priority arbiter
    n.gnt_o = cm_opnd_req;
    n.gnt_i = cm_inst_req & ~cm_opnd_req;
    n.gnt_c = ((q.st == pcfp_pkg::S_MRD) || (q.st == pcfp_pkg::S_MWR))
              & (q.widx < nw) & ~cm_opnd_req & ~cm_inst_req;
    // call answer over the blank parcels
    if (ch_call_in && q.irq) begin
      n.call_cnt = 2'h2;
    end else if (q.call_cnt != 2'h0) begin
      n.call_cnt = q.call_cnt - 2'h1;
    end
    if (q.call_cnt == 2'h2) begin
      n.dout = q.interrupt_call_reply_value;
    end else if (q.call_cnt == 2'h1) begin
      n.dout = pcfp_pkg::RST_HALF;
    end
    // response pulse then two parcels
    if (q.resp_cnt != 2'h0) begin
      n.resp_cnt = q.resp_cnt - 2'h1;
    end
    if (q.resp_cnt == 2'h3) begin
      n.rout = 1'b1;
    end else if (q.resp_cnt == 2'h2) begin
      n.dout = q.resp_data[31:16];
    end else if (q.resp_cnt == 2'h1) begin
      n.dout = q.resp_data[15:0];
    end
    // parcel capture
    if (q.st == pcfp_pkg::S_CAPT) begin
      n.parc[q.pcnt[1:0]] = ch_data_in;
      n.pcnt = q.pcnt + 3'h1;
      if (q.pcnt == 3'h0) begin
        n.mine = (ch_data_in[pcfp_pkg::TYPE_HI:pcfp_pkg::TYPE_LO]
                  == pcfp_pkg::OWN_TYPE)
                 && (ch_data_in[pcfp_pkg::ID_HI:pcfp_pkg::ID_LO]
                  == pcfp_pkg::OWN_ID);
      end
      if (q.pcnt == 3'h3) begin
        n.st = q.mine ? pcfp_pkg::S_EXEC : pcfp_pkg::S_IDLE;
      end
    end
    case (q.st)
      pcfp_pkg::S_IDLE: begin
        if (ch_func_in) begin
          n.st   = pcfp_pkg::S_CAPT;
          n.pcnt = 3'h0;
        end
      end
      pcfp_pkg::S_CAPT: begin
      end
      pcfp_pkg::S_EXEC: begin
        n.st        = pcfp_pkg::S_DONE;
        n.resp_data = pcfp_pkg::RST_WORD;
        n.widx      = 7'h00;
        n.ridx      = 7'h00;
        case (fn)
          pcfp_pkg::F_LOAD: begin
            n.interrupt_call_reply_value = q.parc[1];
            n.memory_reference_pointer = adr;
            n.block_transfer_word_count = lenld(q.len_lock,
              q.block_transfer_word_count, 10'h004);
            n.len_lock = 1'b1;
            n.st = pcfp_pkg::S_MRD;
          end
          pcfp_pkg::F_STORE: begin
            n.memory_reference_pointer = adr;
            n.block_transfer_word_count = lenld(q.len_lock,
              q.block_transfer_word_count, 10'h002);
            n.len_lock = 1'b1;
            n.buff[0] = {pcfp_pkg::RST_WORD, bp_pc_in};
            n.buff[1] = {pcfp_pkg::RST_WORD, q.status};
            n.st = pcfp_pkg::S_MWR;
          end
          pcfp_pkg::F_RUN: begin
            n.interrupt_call_reply_value = q.parc[1];
            n.start_p = 1'b1;
          end
          pcfp_pkg::F_HALT: n.stop_p = 1'b1;
          pcfp_pkg::F_RDPC: n.resp_data = bp_pc_in;
          pcfp_pkg::F_WRPC: begin
            n.pc_val    = adr;
            n.pc_load_p = 1'b1;
          end
          pcfp_pkg::F_RDIF: begin
            case (sub)
              pcfp_pkg::SUB_STAT: n.resp_data = q.status;
              pcfp_pkg::SUB_ADDR: n.resp_data = q.memory_reference_pointer;
              pcfp_pkg::SUB_ERR:  n.resp_data = q.errdata;
              default:            n.resp_data = pcfp_pkg::RST_WORD;
            endcase
          end
          pcfp_pkg::F_WRIF: begin
            n.interrupt_call_reply_value = q.parc[1];
            n.memory_reference_pointer = adr;
            case (sub)
              pcfp_pkg::SUB_STAT: n.status  = adr;
              pcfp_pkg::SUB_ERR:  n.errdata = adr;
              default:            n.errdata = q.errdata;
            endcase
          end
          pcfp_pkg::F_BLKCH, pcfp_pkg::F_CHBLK: begin
            n.memory_reference_pointer = adr;
            n.block_transfer_word_count = lenld(q.len_lock,
              q.block_transfer_word_count, q.parc[1][9:0]);
            n.len_lock = 1'b1;
          end
          pcfp_pkg::F_RDREF: begin
            n.memory_reference_pointer = adr;
            n.block_transfer_word_count = lenld(q.len_lock,
              q.block_transfer_word_count, 10'h001);
            n.len_lock = 1'b1;
            n.st = pcfp_pkg::S_MRD;
          end
          pcfp_pkg::F_RDUP: n.resp_data = q.upper_word_half_holder;
          pcfp_pkg::F_RDLO: n.resp_data = q.lower_word_half_holder;
          pcfp_pkg::F_BLKBF, pcfp_pkg::F_BFMEM: begin
            n.memory_reference_pointer = adr;
            n.block_transfer_word_count = lenld(q.len_lock,
              q.block_transfer_word_count, {3'h0, q.parc[1][6:0]});
            n.len_lock = 1'b1;
            n.st = (fn == pcfp_pkg::F_BLKBF) ? pcfp_pkg::S_MRD
                                             : pcfp_pkg::S_MWR;
          end
          pcfp_pkg::F_BFREF: begin
            {n.upper_word_half_holder, n.lower_word_half_holder} =
              q.buff[q.parc[1][5:0]];
          end
          pcfp_pkg::F_WRREF: begin
            n.memory_reference_pointer = adr;
            n.block_transfer_word_count = lenld(q.len_lock,
              q.block_transfer_word_count, 10'h001);
            n.len_lock = 1'b1;
            n.buff[0] = {q.upper_word_half_holder,
                         q.lower_word_half_holder};
            n.st = pcfp_pkg::S_MWR;
          end
          pcfp_pkg::F_ENUP: n.upper_word_half_holder = adr;
          pcfp_pkg::F_ENLO: n.lower_word_half_holder = adr;
          pcfp_pkg::F_REFBF: begin
            n.buff[q.parc[1][5:0]] = {q.upper_word_half_holder,
                                      q.lower_word_half_holder};
          end
          default: n.st = pcfp_pkg::S_IDLE;
        endcase
      end
      pcfp_pkg::S_MRD: begin
        if (q.gnt_c && (q.widx < nw)) begin
          n.cm_en   = 1'b1;
          n.cm_we   = 1'b0;
          n.cm_addr = q.memory_reference_pointer + {25'h0, q.widx};
          n.widx    = q.widx + 7'h01;
        end
        if (cm_rvalid && (q.ridx < nw)) begin
          n.buff[q.ridx[5:0]] = cm_rdata;
          n.ridx = q.ridx + 7'h01;
        end
        if (q.ridx >= nw) begin
          n.st = pcfp_pkg::S_DONE;
        end
      end
      pcfp_pkg::S_MWR: begin
        if (q.gnt_c && (q.widx < nw)) begin
          n.cm_en    = 1'b1;
          n.cm_we    = 1'b1;
          n.cm_addr  = q.memory_reference_pointer + {25'h0, q.widx};
          n.cm_wdata = q.buff[q.widx[5:0]];
          n.widx     = q.widx + 7'h01;
        end
        if (q.widx >= nw) begin
          n.st = pcfp_pkg::S_DONE;
        end
      end
      pcfp_pkg::S_DONE: begin
        if (fn == pcfp_pkg::F_LOAD) begin
          n.pc_val   = q.buff[0][31:0];
          n.stat_val = q.buff[1][31:0];
          n.base_val = q.buff[2][31:0];
          n.lim_val  = q.buff[3][31:0];
          n.load_p   = 1'b1;
          n.start_p  = 1'b1;
          n.istk_clr = 1'b1;
        end
        if (fn == pcfp_pkg::F_RDREF) begin
          {n.upper_word_half_holder, n.lower_word_half_holder} =
            q.buff[0];
        end
        if (q.resp_cnt == 2'h0) begin
          n.resp_cnt = 2'h3;
          n.len_lock = 1'b0;
          n.st       = ch_func_in ? pcfp_pkg::S_CAPT : pcfp_pkg::S_IDLE;
          n.pcnt     = 3'h0;
        end
      end
      default: n.st = pcfp_pkg::S_IDLE;
    endcase
    // status: hardware sets win over software writes
    n.status = n.status | bp_err_set;
    n.status[pcfp_pkg::IDLE_BIT] = bp_idle;
    err_hit = (q.status & pcfp_pkg::ERR_MASK) != pcfp_pkg::RST_WORD;
    if (!err_hit) begin
      n.stopped = 1'b0;
      n.irq     = 1'b0;
    end else if (!q.stopped) begin
      n.stopped = 1'b1;
      n.stop_p  = 1'b1;
    end else if (q.status[pcfp_pkg::IDLE_BIT]) begin
      n.irq = 1'b1;
    end
  end

  // ***********************************************************************
  // registers
  // ***********************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q    <= '0;
      q.st <= pcfp_pkg::S_IDLE;
    end else begin
      q <= n;
    end
  end

  assign ch_data_out          = q.dout;
  assign ch_func_out          = q.fout;
  assign ch_resp_out          = q.rout;
  assign ch_call_out          = q.cout;
  assign ch_dpls_out          = q.dpout;
  assign cm_gnt_opnd          = q.gnt_o;
  assign cm_gnt_inst          = q.gnt_i;
  assign cm_gnt_chan          = q.gnt_c;
  assign cm_en                = q.cm_en;
  assign cm_we                = q.cm_we;
  assign cm_addr              = q.cm_addr;
  assign cm_wdata             = q.cm_wdata;
  assign bp_stop              = q.stop_p;
  assign bp_start             = q.start_p;
  assign bp_istk_clr          = q.istk_clr;
  assign bp_load              = q.load_p;
  assign bp_pc_load           = q.pc_load_p;
  assign bp_pc_val            = q.pc_val;
  assign bp_stat_val          = q.stat_val;
  assign bp_base_val          = q.base_val;
  assign limit_bound_register = q.lim_val;
endmodule

// [test/pcfp_monitor.sv]
`timescale 1ns/100ps
// ***********
// port checker
// ***********
module pcfp_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ch_func_in,
  input wire logic ch_func_out,
  input wire logic ch_resp_out,
  input wire logic cm_opnd_req,
  input wire logic cm_inst_req,
  input wire logic cm_gnt_opnd,
  input wire logic cm_gnt_inst,
  input wire logic cm_gnt_chan,
  input wire logic cm_en,
  input wire logic bp_stop,
  input wire logic bp_start,
  input wire logic bp_istk_clr,
  input wire logic bp_load
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_gap2;
    !ch_resp_out ##1 !ch_resp_out;
  endsequence
  sequence s_opnd_won;
    cm_gnt_opnd && !cm_gnt_inst && !cm_gnt_chan;
  endsequence
  a_func_relay: assert property (ch_func_out == $past(ch_func_in))
    else $error("function pulse not relayed");
  a_resp_frame: assert property (ch_resp_out |=> s_gap2)
    else $error("response pulse overlaps its parcels");
  a_opnd_first: assert property (cm_opnd_req |=> s_opnd_won)
    else $error("operand request not granted first");
  a_inst_second: assert property (
    cm_inst_req && !cm_opnd_req |=> cm_gnt_inst && !cm_gnt_chan)
    else $error("instruction request not granted");
  a_chan_last: assert property (
    cm_gnt_chan |-> !$past(cm_opnd_req) && !$past(cm_inst_req))
    else $error("channel granted over processor");
  a_chan_access: assert property (cm_en |-> $past(cm_gnt_chan))
    else $error("memory access without grant");
  a_stop_once: assert property (bp_stop |=> !bp_stop)
    else $error("stop pulse too long");
  a_load_group: assert property (bp_load |-> bp_start && bp_istk_clr)
    else $error("load without start and stack clear");
endmodule

// [test/pcfp_mem_model.sv]
`timescale 1ns/100ps
// ***********
// common memory model
// ***********
module pcfp_mem_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        cm_en,
  input  wire logic        cm_we,
  input  wire logic [31:0] cm_addr,
  input  wire logic [63:0] cm_wdata,
  output logic      [63:0] cm_rdata,
  output logic             cm_rvalid
);
  logic [63:0] mem [int];
  logic [63:0] rq  [$];
  int          due [$];
  int          cyc = 0;
  // in-order reads, latency 1 or 6 cycles
  always @(posedge clk) begin
    cyc++;
    if (cm_en && cm_we)
      mem[cm_addr] = cm_wdata;
    if (cm_en && !cm_we) begin
      rq.push_back(mem.exists(cm_addr) ? mem[cm_addr] : {2{~cm_addr}});
      due.push_back(cyc + (slow ? 6 : 1));
    end
    if (due.size() > 0 && due[0] <= cyc) begin
      cm_rvalid <= 1'b1;
      cm_rdata  <= rq.pop_front();
      void'(due.pop_front());
    end else begin
      cm_rvalid <= 1'b0;
      cm_rdata  <= ~cm_rdata;
    end
  end
endmodule

// [test/pcfp_tb_top.sv]
`timescale 1ns/100ps
bind pcfp_top pcfp_monitor u_mon (.clk, .rst_n, .ch_func_in, .ch_func_out,
  .ch_resp_out, .cm_opnd_req, .cm_inst_req, .cm_gnt_opnd, .cm_gnt_inst,
  .cm_gnt_chan, .cm_en, .bp_stop, .bp_start, .bp_istk_clr, .bp_load);
module processor_channel_function_port_tb_top;
  logic        clk, rst_n, ch_func_in, ch_call_in, ch_dpls_in, go, slow;
  logic        ch_resp_in;
  logic [31:0] c, pcv;
  logic        cm_opnd_req, cm_inst_req, bp_idle, cm_rvalid, cm_en, cm_we;
  logic        ch_func_out, ch_resp_out, ch_call_out, ch_dpls_out;
  logic        cm_gnt_opnd, cm_gnt_inst, cm_gnt_chan, bp_stop, bp_start;
  logic        bp_istk_clr, bp_load, bp_pc_load;
  logic [15:0] ch_data_in, ch_data_out, r;
  logic [31:0] bp_pc_in, bp_err_set, cm_addr, bp_pc_val, bp_stat_val;
  logic [31:0] bp_base_val, limit_bound_register, a, u, l, b, ld[4], v[4];
  logic [63:0] cm_wdata, cm_rdata;
  int          n_errors = 0, num_checks = 0, seed = 52320, cyc = 0, stops;
  pcfp_top DUT (.clk, .rst_n, .ch_data_in, .ch_func_in, .ch_resp_in,
    .ch_call_in, .ch_dpls_in, .ch_data_out, .ch_func_out, .ch_resp_out,
    .ch_call_out, .ch_dpls_out, .cm_opnd_req, .cm_inst_req, .cm_gnt_opnd,
    .cm_gnt_inst, .cm_gnt_chan, .cm_en, .cm_we, .cm_addr, .cm_wdata,
    .cm_rdata, .cm_rvalid, .bp_pc_in, .bp_idle, .bp_err_set, .bp_stop,
    .bp_start, .bp_istk_clr, .bp_load, .bp_pc_load, .bp_pc_val,
    .bp_stat_val, .bp_base_val, .limit_bound_register);
  pcfp_mem_model u_mem (.clk, .slow, .cm_en, .cm_we, .cm_addr, .cm_wdata,
    .cm_rdata, .cm_rvalid);
  // ***********
  // clock, timeout, watchers
  // ***********
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (bp_load === 1'b1)
      ld = '{bp_pc_val, bp_stat_val, bp_base_val, limit_bound_register};
    if (bp_pc_load === 1'b1)
      pcv = bp_pc_val;
    if (bp_stop === 1'b1)
      stops++;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
    #1;
    cm_opnd_req = go && (($random(seed) & 3) == 0);
    cm_inst_req = go && (($random(seed) & 3) == 0);
  end
  // ***********
  // tasks
  // ***********
  task summarize;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  task send(input logic [4:0] f, input logic [1:0] id, input logic [1:0] sub,
            input logic [15:0] p1, input logic [31:0] p23);
    logic [15:0] p [4];
    p = '{{pcfp_pkg::OWN_TYPE, f, id, 5'($random(seed)), sub}, p1,
          p23[31:16], p23[15:0]};
    ch_func_in = 1'b1;
    tick;
    ch_func_in = 1'b0;
    foreach (p[i]) begin
      ch_data_in = p[i];
      tick;
    end
  endtask
  task fn(input logic [4:0] f, input logic [1:0] sub, input logic [15:0] p1,
          input logic [31:0] p23, input logic [31:0] exp);
    logic [31:0] w;
    int          k;
    send(f, pcfp_pkg::OWN_ID, sub, p1, p23);
    for (k = 0; k < 400 && ch_resp_out !== 1'b1; k++)
      tick;
    tick;
    w[31:16] = ch_data_out;
    tick;
    w[15:0] = ch_data_out;
    chk(k < 400 ? w : 32'hx, exp);
  endtask
  task none(input logic [4:0] f, input logic [1:0] id);
    int s;
    s = 0;
    send(f, id, 2'h0, 16'h0, 32'h0);
    repeat (20) begin
      tick;
      s += (ch_resp_out !== 1'b0);
    end
    chk(s, 0);
  endtask
  task call(input bit irq, input logic [15:0] rv);
    logic [31:0] x, w;
    x = $random(seed);
    ch_call_in = 1'b1;
    tick;
    ch_call_in = 1'b0;
    ch_data_in = x[31:16];
    tick;
    w[31:16] = ch_data_out;
    ch_data_in = x[15:0];
    tick;
    w[15:0] = ch_data_out;
    chk(w, irq ? {rv, 16'h0} : x);
  endtask
  // ***********
  // main sequence
  // ***********
  initial begin
    {ch_func_in, ch_call_in, ch_dpls_in, go, slow, bp_idle} = 6'h00;
    ch_resp_in = 1'b0;
    rst_n = 1'b0;
    {ch_data_in, bp_pc_in, bp_err_set} = 80'h0;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    go = 1'b1;
    for (int k = 0; k < 16; k++) begin
      {ch_dpls_in, ch_data_in} = 17'($random(seed));
      ch_resp_in = (k % 3 == 0);
      ch_call_in = (k % 3 == 1);
      a = {ch_call_in, ch_resp_in, ch_dpls_in, ch_data_in};
      tick;
      chk({ch_call_out, ch_resp_out, ch_dpls_out, ch_data_out}, a);
    end
    {ch_dpls_in, ch_resp_in, ch_call_in} = 3'h0;
    $display("test relay done");
    bp_pc_in = $random(seed);
    fn(pcfp_pkg::F_RDPC, 2'h0, 16'h0, 32'h0, bp_pc_in);
    none(pcfp_pkg::F_RDPC, 2'h3);
    none(5'h14, pcfp_pkg::OWN_ID);
    $display("test decode done");
    {a, u, l} = {$random(seed), $random(seed), $random(seed)};
    fn(pcfp_pkg::F_WRIF, pcfp_pkg::SUB_ADDR, 16'h1234, a, 32'h0);
    fn(pcfp_pkg::F_RDIF, pcfp_pkg::SUB_ADDR, 16'h0, 32'h0, a);
    fn(pcfp_pkg::F_ENUP, 2'h0, 16'h0, u, 32'h0);
    fn(pcfp_pkg::F_ENLO, 2'h0, 16'h0, l, 32'h0);
    fn(pcfp_pkg::F_RDUP, 2'h0, 16'h0, 32'h0, u);
    fn(pcfp_pkg::F_RDLO, 2'h0, 16'h0, 32'h0, l);
    fn(pcfp_pkg::F_WRPC, 2'h0, 16'h0, u, 32'h0);
    chk(pcv, u);
    $display("test registers done");
    fn(pcfp_pkg::F_STORE, 2'h0, 16'h0, a, 32'h0);
    chk(u_mem.mem[a], {32'h0, bp_pc_in});
    chk(u_mem.mem[a + 32'h1], 64'h0);
    chk(u_mem.mem.exists(a + 32'h2), 1'b0);
    fn(pcfp_pkg::F_RDIF, pcfp_pkg::SUB_ADDR, 16'h0, 32'h0, a);
    $display("test store done");
    b = $random(seed);
    foreach (v[i]) begin
      v[i] = $random(seed);
      u_mem.mem[b + i] = {32'($random(seed)), v[i]};
    end
    bp_idle = 1'b1;
    slow = 1'b1;
    r = $random(seed);
    fn(pcfp_pkg::F_LOAD, 2'h0, r, b, 32'h0);
    foreach (v[i])
      chk(ld[i], v[i]);
    $display("test load done");
    c = $random(seed);
    foreach (v[i])
      u_mem.mem[c + i] = {v[i], ~v[i]};
    fn(pcfp_pkg::F_BLKBF, 2'h0, 16'h0083, c, 32'h0);
    fn(pcfp_pkg::F_BFREF, 2'h0, 16'h0002, 32'h0, 32'h0);
    fn(pcfp_pkg::F_RDUP, 2'h0, 16'h0, 32'h0, v[2]);
    fn(pcfp_pkg::F_RDLO, 2'h0, 16'h0, 32'h0, ~v[2]);
    fn(pcfp_pkg::F_WRREF, 2'h0, 16'h0, c + 32'h8, 32'h0);
    chk(u_mem.mem[c + 32'h8], {v[2], ~v[2]});
    chk(u_mem.mem.exists(c + 32'h9), 1'b0);
    $display("test buffer done");
    stops = 0;
    bp_err_set = 32'h00000100;
    tick;
    bp_err_set = 32'h0;
    repeat (10) tick;
    chk(stops, 1);
    call(1'b1, r);
    fn(pcfp_pkg::F_WRIF, pcfp_pkg::SUB_STAT, 16'h5, 32'h0, 32'h0);
    call(1'b0, 16'h0);
    bp_err_set = 32'h00000200;
    tick;
    bp_err_set = 32'h0;
    repeat (10) tick;
    call(1'b1, 16'h5);
    $display("test error done");
    summarize();
  end
endmodule
